//--- rtl/hrs_return_stack.sv
// Hardware return stack with APB access, flags and interrupt
//
// Notes on behaviour
// - Sixteen entries, each fifteen bits wide
// - Storage reachable only through the stack pointer
// - Call, call-through-W, interrupt entry push the PC
// - Return, return-literal, return-interrupt pop the stack
// - Push and pop never touch PC upper latch
// - Error reset off: stack wraps like circular buffer
// - Overflow and underflow flags always set
// - Pointer selects entry shown in top registers
// - Top entry split high/low, both read-write
// - Five-bit pointer exposes overflow and underflow
// - Push increments pointer, pop decrements it
// - Pointer addresses the entry currently in use
// - Push: bump then write; pop: read then drop
`timescale 1ns/100ps
module hrs_return_stack (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic PUSH_REQ,
  input wire logic [14:0] PUSH_PC,
  input wire logic POP_REQ,
  output logic [14:0] RET_PC,
  output logic RET_VALID,
  output logic IRQ,
  output logic STACK_ERR_RESET
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  logic [4:0] stack_index_reg;            // Pointer to entry in use
  logic [4:0] stack_index_next;           // Next pointer value
  logic [1:0] flags_reg;                  // Overflow and underflow flags
  logic [1:0] flags_next;                 // Next flag value
  logic [1:0] enable_reg;                 // Interrupt enables
  logic err_rst_en_reg;                   // Stack error reset enable
  logic [14:0] ret_pc_reg;                // Popped program counter
  logic ret_valid_reg;                    // Pop result strobe
  logic [1:0] event_reg;                  // Error events of last edge
  logic err_reset_reg;                    // Device reset request
  logic [31:0] prdata_reg;                // Registered read data
  logic [31:0] prdata_next;               // Read mux

  // ------------------------------------------------------------
  // Sequencer side decode
  // ------------------------------------------------------------
  logic do_push;                          // Push this cycle
  logic do_pop;                           // Pop this cycle
  logic [4:0] index_inc;                  // Pointer plus one
  logic [4:0] index_dec;                  // Pointer minus one
  logic ovf_event;                        // Push ran past the last entry
  logic unf_event;                        // Pop from an empty stack
  logic [14:0] stack_top;                 // Entry at the pointer

  // Push wins a collision; the sequencer never asks for both at once
  assign do_push = PUSH_REQ;
  assign do_pop = POP_REQ && !PUSH_REQ;
  assign index_inc = stack_index_reg + 5'h01;
  assign index_dec = stack_index_reg - 5'h01;
  // Spare pointer bit makes both error cases visible
  assign ovf_event = do_push && (stack_index_reg == hrs_pkg::INDEX_LAST);
  assign unf_event = do_pop && (stack_index_reg == hrs_pkg::INDEX_EMPTY);

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  logic apb_setup;                        // Setup phase
  logic apb_wr;                           // Write completes this edge
  logic sel_low;                          // Top entry low selected
  logic sel_high;                         // Top entry high selected
  logic sel_index;                        // Pointer selected
  logic sel_ctrl;                         // Config selected
  logic sel_status;                       // Status selected
  logic sel_clear;                        // Clear selected
  logic sel_enable;                       // Enable selected
  logic sel_any;                          // Mapped address
  logic seq_busy;                         // Sequencer moves the stack

  assign apb_setup = PSEL && !PENABLE;
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign sel_low = (PADDR == hrs_pkg::OFS_TOP_LOW);
  assign sel_high = (PADDR == hrs_pkg::OFS_TOP_HIGH);
  assign sel_index = (PADDR == hrs_pkg::OFS_INDEX);
  assign sel_ctrl = (PADDR == hrs_pkg::OFS_CTRL);
  assign sel_status = (PADDR == hrs_pkg::OFS_STATUS);
  assign sel_clear = (PADDR == hrs_pkg::OFS_CLEAR);
  assign sel_enable = (PADDR == hrs_pkg::OFS_ENABLE);
  assign sel_any = sel_low | sel_high | sel_index | sel_ctrl | sel_status
                 | sel_clear | sel_enable;
  assign seq_busy = do_push || do_pop;

  // Zero wait states: the stack top is always current
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !sel_any;
  assign PRDATA = prdata_reg;

  // ------------------------------------------------------------
  // Storage write port
  // ------------------------------------------------------------
  logic mem_we;                           // Array write enable
  logic [3:0] mem_waddr;                  // Array write address
  logic [14:0] mem_wdata;                 // Array write data
  logic sw_top_wr;                        // Software writes top entry
  logic [14:0] sw_top_data;               // Merged top entry from software

  // Software writes a byte of the entry the pointer selects
  assign sw_top_wr = apb_wr && (sel_low || sel_high) && !seq_busy;
  assign sw_top_data = sel_low
    ? {stack_top[14:8], PWDATA[7:0]}
    : {PWDATA[6:0], stack_top[7:0]};
  // Push writes the slot after the bump; low bits wrap the array
  assign mem_we = do_push || sw_top_wr;
  assign mem_waddr = do_push ? index_inc[3:0] : stack_index_reg[3:0];
  assign mem_wdata = do_push ? PUSH_PC : sw_top_data;

  // ------------------------------------------------------------
  // Pointer next value
  // ------------------------------------------------------------
  // Software pointer writes yield to a sequencer move in the same cycle
  always_comb begin
    stack_index_next = stack_index_reg;
    if (do_push) begin
      stack_index_next = index_inc;
    end else if (do_pop) begin
      stack_index_next = index_dec;
    end else if (apb_wr && sel_index) begin
      stack_index_next = PWDATA[4:0];
    end
  end

  // ------------------------------------------------------------
  // Storage, separate from all program and data addresses
  // ------------------------------------------------------------
  // Read address follows the next pointer so the read word matches it
  hrs_stack_mem #(
    .DEPTH(hrs_pkg::STACK_DEPTH),
    .WIDTH(hrs_pkg::PC_WIDTH),
    .AW(hrs_pkg::ADDR_WIDTH)
  ) u_mem (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .wr_en(mem_we),
    .wr_addr(mem_waddr),
    .wr_data(mem_wdata),
    .rd_addr(stack_index_next[3:0]),
    .rd_data(stack_top)
  );

  // Pointer register
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stack_index_reg <= hrs_pkg::INDEX_RESET;
    end else begin
      stack_index_reg <= stack_index_next;
    end
  end

  // ------------------------------------------------------------
  // Pop result
  // ------------------------------------------------------------
  // Entry is taken before the pointer drops; no latch state is kept here
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ret_pc_reg <= '0;
      ret_valid_reg <= 1'b0;
    end else begin
      ret_valid_reg <= do_pop;
      if (do_pop) begin
        ret_pc_reg <= stack_top;
      end
    end
  end

  assign RET_PC = ret_pc_reg;
  assign RET_VALID = ret_valid_reg;

  // ------------------------------------------------------------
  // Flags: set beats clear in the same cycle
  // ------------------------------------------------------------
  logic [1:0] flag_set;                   // Error events as flags
  logic [1:0] flag_clr;                   // Software clear mask

  assign flag_set = {unf_event, ovf_event};
  assign flag_clr = (apb_wr && sel_clear) ? PWDATA[1:0] : 2'h0;
  assign flags_next = (flags_reg & ~flag_clr) | flag_set;

  // Flag and config registers
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_reg <= hrs_pkg::FLAGS_RESET;
      enable_reg <= hrs_pkg::ENABLE_RESET;
      err_rst_en_reg <= hrs_pkg::CTRL_RESET;
    end else begin
      flags_reg <= flags_next;
      if (apb_wr && sel_enable) begin
        enable_reg <= PWDATA[1:0];
      end
      if (apb_wr && sel_ctrl) begin
        err_rst_en_reg <= PWDATA[hrs_pkg::BIT_ERR_RST_EN];
      end
    end
  end

  // Level interrupt from enabled sticky flags
  assign IRQ = |(flags_reg & enable_reg);

  // ------------------------------------------------------------
  // Stack error reset
  // ------------------------------------------------------------
  // Request trails the flag by one cycle so the flag is seen first
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      event_reg <= 2'h0;
      err_reset_reg <= 1'b0;
    end else begin
      event_reg <= flag_set;
      err_reset_reg <= (|event_reg) && err_rst_en_reg;
    end
  end

  assign STACK_ERR_RESET = err_reset_reg;

  // ------------------------------------------------------------
  // Register read mux, latched in the setup phase
  // ------------------------------------------------------------
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (sel_low) begin
      prdata_next[7:0] = stack_top[7:0];
    end else if (sel_high) begin
      prdata_next[6:0] = stack_top[14:8];
    end else if (sel_index) begin
      prdata_next[4:0] = stack_index_reg;
    end else if (sel_ctrl) begin
      prdata_next[hrs_pkg::BIT_ERR_RST_EN] = err_rst_en_reg;
    end else if (sel_status) begin
      prdata_next[1:0] = flags_reg;
    end else if (sel_enable) begin
      prdata_next[1:0] = enable_reg;
    end
  end

  // Read data register
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      prdata_reg <= 32'h0000_0000;
    end else if (apb_setup && !PWRITE) begin
      prdata_reg <= prdata_next;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  // A push immediately followed by a pop
  sequence push_then_pop_s;
    PUSH_REQ ##1 (POP_REQ && !PUSH_REQ);
  endsequence

  // An overflow or underflow event
  sequence stack_err_s;
    (ovf_event || unf_event);
  endsequence

  push_ptr_a: assert property (PUSH_REQ |=> stack_index_reg == $past(stack_index_reg) + 5'h01)
    else $error("Push did not raise the pointer by one");

  pop_ptr_a: assert property ((POP_REQ && !PUSH_REQ)
    |=> stack_index_reg == $past(stack_index_reg) - 5'h01)
    else $error("Pop did not lower the pointer by one");

  ovf_flag_a: assert property ((PUSH_REQ && stack_index_reg == 5'h0F) |=> flags_reg[0])
    else $error("Overflow flag not set");

  unf_flag_a: assert property ((POP_REQ && !PUSH_REQ && stack_index_reg == 5'h1F)
    |=> flags_reg[1])
    else $error("Underflow flag not set");

  pop_data_a: assert property (push_then_pop_s
    |=> (RET_VALID && RET_PC == $past(PUSH_PC, 2)))
    else $error("Pop did not return the last pushed PC");

  ret_strobe_a: assert property ((POP_REQ && !PUSH_REQ) |=> RET_VALID)
    else $error("Return strobe missing after a pop");
  ret_quiet_a: assert property (!(POP_REQ && !PUSH_REQ) |=> !RET_VALID)
    else $error("Return strobe without a pop");

  err_rst_on_a: assert property ((stack_err_s ##0 err_rst_en_reg) ##1 err_rst_en_reg
    |=> STACK_ERR_RESET)
    else $error("Error reset not raised");

  err_rst_off_a: assert property (STACK_ERR_RESET
    |-> $past(err_rst_en_reg) && ($past(event_reg) != 2'h0))
    else $error("Error reset raised without cause");

  set_wins_a: assert property ((ovf_event && apb_wr && sel_clear && PWDATA[0])
    |=> flags_reg[0])
    else $error("Clear beat a new overflow");

  wrap_a: assert property ((PUSH_REQ && stack_index_reg == 5'h0F) ##1 (POP_REQ && !PUSH_REQ)
    |=> RET_PC == $past(PUSH_PC, 2))
    else $error("Wrapped entry not returned");

endmodule

//--- common/hrs_pkg.sv
// Shared constants for the hardware return stack
package hrs_pkg;

  // ------------------------------------------------------------
  // Stack geometry
  // ------------------------------------------------------------
  localparam int STACK_DEPTH = 16;        // Entries in the stack
  localparam int PC_WIDTH = 15;           // Program counter width
  localparam int INDEX_WIDTH = 5;         // Pointer width, one spare bit
  localparam int ADDR_WIDTH = 4;          // Entry address width

  // ------------------------------------------------------------
  // Pointer values
  // ------------------------------------------------------------
  localparam logic [4:0] INDEX_RESET = 5'h1F;   // Empty stack after reset
  localparam logic [4:0] INDEX_LAST = 5'h0F;    // Last valid entry
  localparam logic [4:0] INDEX_EMPTY = 5'h1F;   // Pop from here underflows

  // ------------------------------------------------------------
  // Register byte offsets on the APB
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_TOP_LOW = 8'h00;   // Top entry bits 7:0
  localparam logic [7:0] OFS_TOP_HIGH = 8'h04;  // Top entry bits 14:8
  localparam logic [7:0] OFS_INDEX = 8'h08;     // Stack pointer
  localparam logic [7:0] OFS_CTRL = 8'h0C;      // Configuration
  localparam logic [7:0] OFS_STATUS = 8'h10;    // Sticky flags, read only
  localparam logic [7:0] OFS_CLEAR = 8'h14;     // Write one to clear
  localparam logic [7:0] OFS_ENABLE = 8'h18;    // Interrupt enables

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int LOW_BITS = 8;            // Width of low top-entry field
  localparam int HIGH_BITS = 7;           // Width of high top-entry field
  localparam int BIT_OVF = 0;             // Overflow flag position
  localparam int BIT_UNF = 1;             // Underflow flag position
  localparam int BIT_ERR_RST_EN = 0;      // Error reset enable position
  localparam int FLAG_BITS = 2;           // Flags in status layout

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [1:0] FLAGS_RESET = 2'h0;    // No flag set
  localparam logic [1:0] ENABLE_RESET = 2'h0;   // Interrupts masked
  localparam logic CTRL_RESET = 1'b0;           // Circular mode

endpackage

//--- rtl/hrs_stack_mem.sv
// Storage array for the return stack entries
`timescale 1ns/100ps
module hrs_stack_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 15,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  // ------------------------------------------------------------
  // Array and read register
  // ------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];   // Entries, no reset needed
  logic [WIDTH-1:0] rd_reg;          // Registered read data
  logic [WIDTH-1:0] rd_next;         // Read data with write bypass

  // Bypass so the read word always matches the array after this edge
  assign rd_next = (wr_en && (wr_addr == rd_addr)) ? wr_data : mem_q[rd_addr];
  assign rd_data = rd_reg;

  // Write port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_reg <= '0;
    end else begin
      rd_reg <= rd_next;
    end
  end

endmodule

//--- tb/hrs_seq_model.sv
// Sequencer stand-in that issues push and pop pulses to the stack
`timescale 1ns/100ps
module hrs_seq_model (
  input wire logic clk,
  output logic push_req,
  output logic [14:0] push_pc,
  output logic pop_req
);
  // ----------------------------------------------------------
  // Idle levels at time zero
  // ----------------------------------------------------------
  initial begin
    push_req = 1'b0;
    push_pc = 15'h7FFF;
    pop_req = 1'b0;
  end

  // ----------------------------------------------------------
  // Call or interrupt entry, then gap idle cycles (slow core)
  // ----------------------------------------------------------
  task automatic push(input logic [14:0] pc, input int gap);
    @(posedge clk);
    push_req <= 1'b1;
    push_pc <= pc;
    @(posedge clk);
    push_req <= 1'b0;
    // Inverted stale value, so a late sample cannot pass by luck
    push_pc <= ~pc;
    repeat (gap) @(posedge clk);
  endtask

  // ----------------------------------------------------------
  // Call followed by a return on the very next cycle
  // ----------------------------------------------------------
  task automatic push_pop(input logic [14:0] pc);
    @(posedge clk);
    push_req <= 1'b1;
    push_pc <= pc;
    @(posedge clk);
    push_req <= 1'b0;
    push_pc <= ~pc;
    pop_req <= 1'b1;
    @(posedge clk);
    pop_req <= 1'b0;
  endtask

  // ----------------------------------------------------------
  // Return of any kind, then gap idle cycles
  // ----------------------------------------------------------
  task automatic pop(input int gap);
    @(posedge clk);
    pop_req <= 1'b1;
    @(posedge clk);
    pop_req <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask
endmodule

//--- tb/hrs_return_stack_tb_top.sv
// Self-checking bench for the hardware return stack
`timescale 1ns/100ps
module hrs_return_stack_tb_top;
  // ----------------------------------------------------------
  // Signals and mirror state
  // ----------------------------------------------------------
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, push_req, pop_req, ret_valid, irq, err_rst;
  logic [14:0] push_pc, ret_pc, v;
  logic [32:0] rd_q[$]; // Expected error bit and data per read
  logic [14:0] ret_q[$]; // Expected popped values, oldest first
  logic [14:0] mem[16]; // Mirror of the entries
  logic [4:0] ptr = 5'h1F; // Mirror of the pointer
  logic [1:0] flags = 2'h0;
  logic [1:0] en = 2'h0;
  logic ctrl = 1'b0;
  logic [31:0] seed = 32'h1E;
  int failures = 0;
  int check_count = 0;
  int exp_pulses = 0;
  int pulses = 0;
  int cycles = 0;

  initial forever #10 core_clk = ~core_clk;

  hrs_return_stack hrs_return_stack_inst (.CORE_CLK(core_clk), .RST_N(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PUSH_REQ(push_req), .PUSH_PC(push_pc),
    .POP_REQ(pop_req), .RET_PC(ret_pc), .RET_VALID(ret_valid), .IRQ(irq),
    .STACK_ERR_RESET(err_rst));
  hrs_seq_model hrs_seq_model_inst (.clk(core_clk), .push_req(push_req), .push_pc(push_pc),
    .pop_req(pop_req));

  // ----------------------------------------------------------
  // Helpers: random source, compares, verdict
  // ----------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check_word(input logic [32:0] got, input logic [32:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_word({32'h0, got}, {32'h0, exp});
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Watcher: takes the oldest note whenever a result appears
  // ----------------------------------------------------------
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (rst_n && err_rst)
      pulses <= pulses + 1;
    if (psel && penable && pready && !pwrite)
      check_word({pslverr, prdata}, rd_q.size() > 0 ? rd_q.pop_front() : 33'h1FFFFFFFF);
    if (ret_valid)
      check_word({18'h0, ret_pc}, ret_q.size() > 0 ? {18'h0, ret_q.pop_front()} : 33'h1FFFFFFFF);
    // Hang guard, far above the few hundred cycles the run needs
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------
  // APB master: hold everything until pready is seen high
  // ----------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1)
      @(posedge core_clk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] addr, input logic [32:0] exp);
    rd_q.push_back(exp);
    apb(1'b0, addr, 32'h0);
  endtask

  // ----------------------------------------------------------
  // Stack operations, mirrored before they are issued
  // ----------------------------------------------------------
  task automatic do_push(input logic [14:0] pc, input bit then_pop = 1'b0);
    if (ptr == 5'h0F) begin
      flags[0] = 1'b1;
      exp_pulses += ctrl;
    end
    ptr = ptr + 5'h01;
    mem[ptr[3:0]] = pc;
    // Pop of the fresh entry next cycle; callers keep clear of the empty code
    if (then_pop) begin
      ret_q.push_back(pc);
      ptr = ptr - 5'h01;
      hrs_seq_model_inst.push_pop(pc);
    end else begin
      hrs_seq_model_inst.push(pc, rnd() % 3);
    end
  endtask
  task automatic do_pop();
    if (ptr == 5'h1F) begin
      flags[1] = 1'b1;
      exp_pulses += ctrl;
    end
    ret_q.push_back(mem[ptr[3:0]]);
    ptr = ptr - 5'h01;
    hrs_seq_model_inst.pop(rnd() % 3);
  endtask
  task automatic check_state();
    rd(hrs_pkg::OFS_INDEX, {28'h0, ptr});
    rd(hrs_pkg::OFS_STATUS, {31'h0, flags});
    @(negedge core_clk);
    check_bit(irq, |(flags & en));
    check_bit(pready, 1'b1);
    check_word(33'(ret_q.size()), 33'h0);
    check_word(33'(pulses), 33'(exp_pulses));
  endtask

  // ----------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(hrs_pkg::OFS_CTRL, 33'h0);
    rd(hrs_pkg::OFS_ENABLE, 33'h0);
    rd(hrs_pkg::OFS_CLEAR, 33'h0);
    rd(8'h1C, 33'h100000000);
    apb(1'b1, hrs_pkg::OFS_STATUS, 32'h3);
    check_state();
    en = 2'h3;
    apb(1'b1, hrs_pkg::OFS_ENABLE, 32'h3);
    // Seventeen pushes wrap onto entry 0, eighteen pops underflow
    for (int i = 0; i < 35; i++) begin
      if (i < 17)
        do_push(15'(rnd()), i == 16);
      else
        do_pop();
    end
    check_state();
    apb(1'b1, hrs_pkg::OFS_CLEAR, 32'h1);
    flags[0] = 1'b0;
    check_state();
    en = 2'h1;
    apb(1'b1, hrs_pkg::OFS_ENABLE, 32'h1);
    check_state();
    apb(1'b1, hrs_pkg::OFS_CLEAR, 32'h2);
    flags = 2'h0;
    ctrl = 1'b1;
    apb(1'b1, hrs_pkg::OFS_CTRL, 32'h1);
    for (int r = 0; r < 4; r++) begin
      for (int i = 0; i < 20; i++) begin
        if (rnd() % 2 == 0)
          do_push(15'(rnd()));
        else
          do_pop();
      end
      check_state();
      // Pointer moved only while the sequencer is idle
      ptr = 5'(rnd());
      apb(1'b1, hrs_pkg::OFS_INDEX, {27'h0, ptr});
      rd(hrs_pkg::OFS_TOP_LOW, {25'h0, mem[ptr[3:0]][7:0]});
      rd(hrs_pkg::OFS_TOP_HIGH, {26'h0, mem[ptr[3:0]][14:8]});
      v = 15'(rnd());
      mem[ptr[3:0]] = v;
      apb(1'b1, hrs_pkg::OFS_TOP_LOW, {24'h0, v[7:0]});
      apb(1'b1, hrs_pkg::OFS_TOP_HIGH, {25'h0, v[14:8]});
      do_pop();
      do_pop();
    end
    // Overflow and a clear of it land on one edge: the set must win
    ptr = 5'h0F;
    apb(1'b1, hrs_pkg::OFS_INDEX, 32'h0000000F);
    fork
      apb(1'b1, hrs_pkg::OFS_CLEAR, 32'h1);
      begin
        @(posedge core_clk);
        do_push(15'(rnd()));
      end
    join
    check_state();
    repeat (4) @(posedge core_clk);
    report_and_stop();
  end
endmodule
